// ---- common/setup_cmd_map.vh ----
`ifndef SETUP_CMD_MAP_VH
`define SETUP_CMD_MAP_VH
// Wishbone register byte offsets
`define REG_CMD_OUT 4'h0
`define REG_DATA_IN 4'h4
`define REG_STATUS 4'h8
`define REG_FLAGS 4'hC
// Status register bit positions
`define ST_DATA_IN_FULL 2
`define ST_CMD_PORT_FULL 3
`define ST_IDLE 4
`define ST_INIT_REQ 5
// Flags register bit positions, write one to clear
`define FL_COMPLETE 0
`define FL_INVALID 1
// Opcodes
`define OP_NOP 8'h00
`define OP_MBX_SETUP 8'h01
`define OP_START_SCAN 8'h02
`define OP_FW_BOOT 8'h03
`define OP_INQUIRY 8'h04
`define OP_OUT_INT 8'h05
// Parameter values and sizes
`define OUT_INT_OFF 8'h00
`define OUT_INT_ON 8'h01
`define MBX_ENTRY_BYTES 11'h008
// Identity bytes, values arbitrary
`define BOARD_ID 8'h5A
`define OPTIONS_ID 8'h5B
`define FW_DIGIT1 8'h32
`define FW_DIGIT2 8'h37
`endif

// ---- logic/byte_slot.v ----
`timescale 1ns/100ps
`default_nettype none
// One-byte port holding register with full flag
module byte_slot
(
	input wire clk,
	input wire nrst,
	input wire load,
	input wire [7:0] loadData,
	input wire take,
	output reg [7:0] data_r,
	output reg full_r
);
	// Load wins over take so a fresh byte is never lost
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			data_r <= 8'h00;
			full_r <= 1'b0;
		end
		else if (load)
		begin
			data_r <= loadData;
			full_r <= 1'b1;
		end
		else if (take)
			full_r <= 1'b0;
	end
endmodule // byte_slot
`default_nettype wire

// ---- logic/host_adapter_setup_commands.v ----
`timescale 1ns/100ps
`default_nettype none
`include "setup_cmd_map.vh"
module host_adapter_setup_commands
(
	input wire clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire scanDone,
	output reg scanActive_r,
	output reg [23:0] mbxBase_r,
	output reg [7:0] mbxCount_r,
	output reg [23:0] mbxInBase_r,
	output reg [10:0] mbxAreaBytes_r,
	output reg outIntEnable_r,
	output reg commandComplete_r,
	output reg invalidCommand_r,
	output reg initRequired_r
);
	localparam ST_OPCODE = 3'd0;
	localparam ST_PARAM = 3'd1;
	localparam ST_CHECK = 3'd2;
	localparam ST_REPLY = 3'd3;
	localparam ST_WAIT_READ = 3'd4;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [7:0] opcode_r;
	reg [1:0] byteCnt_r;
	reg [7:0] pCount_r;
	reg [23:0] pAddr_r;
	reg mbxValid_r;
	wire [7:0] cmdByte;
	wire cmdFull;
	wire [7:0] replyByte;
	wire replyFull;
	reg cmdTake;
	reg replyLoad;
	reg [7:0] replyData;
	reg setComplete;
	reg setInvalid;
	reg setupOk;

	wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wrLow = busReq & wb_we_i & wb_sel_i[0];
	wire cmdWrite = wrLow & (wb_adr_i == `REG_CMD_OUT) & ~cmdFull;
	wire replyRead = busReq & ~wb_we_i & (wb_adr_i == `REG_DATA_IN);
	wire flagWrite = wrLow & (wb_adr_i == `REG_FLAGS);
	wire idle = (state_r == ST_OPCODE) & ~cmdFull;

	// Command/data-out port; a write while full is dropped
	byte_slot cmdSlot
	(
		.clk(clk),
		.nrst(nrst),
		.load(cmdWrite),
		.loadData(wb_dat_i[7:0]),
		.take(cmdTake),
		.data_r(cmdByte),
		.full_r(cmdFull)
	);

	byte_slot replySlot
	(
		.clk(clk),
		.nrst(nrst),
		.load(replyLoad),
		.loadData(replyData),
		.take(replyRead),
		.data_r(replyByte),
		.full_r(replyFull)
	);

	// Inquiry reply byte selection
	always @*
	begin
		case (byteCnt_r)
			2'd0: replyData = `BOARD_ID;
			2'd1: replyData = `OPTIONS_ID;
			2'd2: replyData = `FW_DIGIT1;
			default: replyData = `FW_DIGIT2;
		endcase
	end

	// Command sequencer
	always @*
	begin
		state_nxt = state_r;
		cmdTake = 1'b0;
		replyLoad = 1'b0;
		setComplete = 1'b0;
		setInvalid = 1'b0;
		setupOk = 1'b0;
		case (state_r)
			ST_OPCODE:
			begin
				if (cmdFull)
				begin
					cmdTake = 1'b1;
					case (cmdByte)
						`OP_MBX_SETUP, `OP_OUT_INT: state_nxt = ST_PARAM;
						`OP_INQUIRY: state_nxt = ST_REPLY;
						`OP_START_SCAN:
						begin
							if (!mbxValid_r)
							begin
								setInvalid = 1'b1;
								setComplete = 1'b1;
							end
						end
						`OP_FW_BOOT:
						begin
							setInvalid = 1'b1;
							setComplete = 1'b1;
						end
						`OP_NOP: setComplete = 1'b1;
						default:
						begin
							setInvalid = 1'b1;
							setComplete = 1'b1;
						end
					endcase
				end
			end
			ST_PARAM:
			begin
				if (cmdFull)
				begin
					cmdTake = 1'b1;
					if (opcode_r == `OP_OUT_INT || byteCnt_r == 2'd3)
						state_nxt = ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				state_nxt = ST_OPCODE;
				if (opcode_r == `OP_OUT_INT)
				begin
					if (pCount_r != `OUT_INT_OFF && pCount_r != `OUT_INT_ON)
					begin
						setInvalid = 1'b1;
						setComplete = 1'b1;
					end
				end
				else if (pCount_r == 8'h00)
				begin
					setInvalid = 1'b1;
					setComplete = 1'b1;
				end
				else
				begin
					setupOk = 1'b1;
					setComplete = 1'b1;
				end
			end
			ST_REPLY:
			begin
				if (!replyFull)
				begin
					replyLoad = 1'b1;
					state_nxt = ST_WAIT_READ;
				end
			end
			ST_WAIT_READ:
			begin
				if (!replyFull)
				begin
					if (byteCnt_r == 2'd3)
					begin
						setComplete = 1'b1;
						state_nxt = ST_OPCODE;
					end
					else
						state_nxt = ST_REPLY;
				end
			end
			default: state_nxt = ST_OPCODE;
		endcase
	end

	// State, parameter capture and configuration
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			state_r <= ST_OPCODE;
			opcode_r <= 8'h00;
			byteCnt_r <= 2'd0;
			pCount_r <= 8'h00;
			pAddr_r <= 24'h00_0000;
			mbxValid_r <= 1'b0;
			mbxBase_r <= 24'h00_0000;
			mbxCount_r <= 8'h00;
			mbxInBase_r <= 24'h00_0000;
			mbxAreaBytes_r <= 11'h000;
			outIntEnable_r <= 1'b0;
			initRequired_r <= 1'b1;
			scanActive_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == ST_OPCODE && cmdTake)
			begin
				opcode_r <= cmdByte;
				byteCnt_r <= 2'd0;
			end
			// count first, then address high to low
			if (state_r == ST_PARAM && cmdTake)
			begin
				if (byteCnt_r == 2'd0)
					pCount_r <= cmdByte;
				else
					pAddr_r <= {pAddr_r[15:0], cmdByte};
				byteCnt_r <= byteCnt_r + 2'd1;
			end
			if (state_r == ST_WAIT_READ && !replyFull)
				byteCnt_r <= byteCnt_r + 2'd1;
			if (state_r == ST_CHECK && opcode_r == `OP_OUT_INT &&
				(pCount_r == `OUT_INT_OFF || pCount_r == `OUT_INT_ON))
				outIntEnable_r <= pCount_r[0];
			// only a good setup touches the mailbox configuration
			if (setupOk)
			begin
				mbxValid_r <= 1'b1;
				mbxBase_r <= pAddr_r;
				mbxCount_r <= pCount_r;
				// in entries follow count out entries
				mbxInBase_r <= pAddr_r + {13'h0000, pCount_r, 3'b000} / 24'd2;
				mbxAreaBytes_r <= {3'b000, pCount_r} * `MBX_ENTRY_BYTES;
				initRequired_r <= 1'b0;
			end
			// scan runs until the scan engine raises scanDone
			if (state_r == ST_OPCODE && cmdTake && cmdByte == `OP_START_SCAN && mbxValid_r)
				scanActive_r <= 1'b1;
			else if (scanDone)
				scanActive_r <= 1'b0;
		end
	end

	// Sticky flags: hardware set wins over software clear
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			commandComplete_r <= 1'b0;
			invalidCommand_r <= 1'b0;
		end
		else
		begin
			if (setComplete)
				commandComplete_r <= 1'b1;
			else if (flagWrite && wb_dat_i[`FL_COMPLETE])
				commandComplete_r <= 1'b0;
			if (setInvalid)
				invalidCommand_r <= 1'b1;
			else if (flagWrite && wb_dat_i[`FL_INVALID])
				invalidCommand_r <= 1'b0;
		end
	end

	// Wishbone slave, one wait state, unmapped reads zero
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= busReq;
			wb_dat_o <= 32'h0000_0000;
			if (busReq && !wb_we_i)
			begin
				case (wb_adr_i)
					`REG_DATA_IN: wb_dat_o <= {24'h00_0000, replyByte};
					`REG_STATUS: wb_dat_o <= {26'h000_0000, initRequired_r, idle, cmdFull, replyFull, 2'b00};
					`REG_FLAGS: wb_dat_o <= {30'h0000_0000, invalidCommand_r, commandComplete_r};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // host_adapter_setup_commands
`default_nettype wire

// ---- bench/setup_cmd_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the setup command block
module setup_cmd_assertions
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic scanActive_r,
	input wire logic [23:0] mbxBase_r,
	input wire logic [7:0] mbxCount_r,
	input wire logic [23:0] mbxInBase_r,
	input wire logic [10:0] mbxAreaBytes_r,
	input wire logic outIntEnable_r,
	input wire logic commandComplete_r,
	input wire logic invalidCommand_r,
	input wire logic initRequired_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Past-reset guards keep a mid-run reset from firing count_kept_a, init_done_a, scan_quiet_a and int_quiet_a
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a one cycle pulse");
	mbx_area_a: assert property (!initRequired_r |-> ##2 mbxAreaBytes_r == {mbxCount_r, 3'h0})
		else $error("mailbox area size wrong");
	in_base_a: assert property (!initRequired_r |-> ##2 mbxInBase_r == mbxBase_r + {14'h0, mbxCount_r, 2'h0})
		else $error("incoming entries base wrong");
	count_kept_a: assert property ($past(nrst) && $changed(mbxCount_r) |-> mbxCount_r != 8'h00)
		else $error("zero count was stored");
	init_done_a: assert property ($past(nrst) && $fell(initRequired_r) |-> ##[0:1] commandComplete_r)
		else $error("setup done without complete flag");
	scan_gate_a: assert property ($rose(scanActive_r) |-> !initRequired_r)
		else $error("scan started before setup");
	scan_quiet_a: assert property ($past(nrst) && $rose(scanActive_r) |-> $stable(commandComplete_r) [*3])
		else $error("scan start raised complete flag");
	int_quiet_a: assert property ($past(nrst) && $changed(outIntEnable_r) |-> !invalidCommand_r [*2])
		else $error("valid enable byte flagged invalid");
endmodule // setup_cmd_assertions
bind host_adapter_setup_commands setup_cmd_assertions chk_u (.*);
`default_nettype wire

// ---- bench/scan_engine_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Stand-in scan engine; a long delay lets the bench see the scan running
module scan_engine_model
#(
	parameter int DLY = 40
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic scanActive_r,
	output logic scanDone
);
	logic [7:0] cnt_r;
	always @(posedge clk)
	begin
		cnt_r <= (!nrst || !scanActive_r) ? 8'h00 : cnt_r + 8'h01;
		scanDone <= nrst && scanActive_r && cnt_r == DLY[7:0];
	end
endmodule // scan_engine_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "setup_cmd_map.vh"
module tb_top;
	logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, scanDone, scanActive_r, outIntEnable_r;
	logic commandComplete_r, invalidCommand_r, initRequired_r, en;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [23:0] mbxBase_r, mbxInBase_r, mbxA;
	logic [7:0] mbxCount_r, mbxN, v;
	logic [10:0] mbxAreaBytes_r;
	logic [63:0] expQ[$];
	logic [7:0] idb[4] = '{`BOARD_ID, `OPTIONS_ID, `FW_DIGIT1, `FW_DIGIT2};
	int mismatches, nCompared, cycles, seed, i;
	host_adapter_setup_commands dut_u (.*);
	scan_engine_model scan_u (.*);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One bus cycle held until acknowledged; reads note their expectation
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
		if (!w)
			expQ.push_back({m, e});
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask
	task ready;
		do acc(1'b0, `REG_STATUS, 32'h0, 32'h0, 32'h0); while (rd[`ST_CMD_PORT_FULL]);
	endtask
	task put(input logic [7:0] b);
		ready;
		acc(1'b1, `REG_CMD_OUT, {24'h0, b}, 32'h0, 32'h0);
	endtask
	// opcodes wait for the idle bit
	task issue(input logic [7:0] op);
		do acc(1'b0, `REG_STATUS, 32'h0, 32'h0, 32'h0); while (!rd[`ST_IDLE]);
		put(op);
	endtask
	task settle;
		ready;
		repeat (3) @(posedge clk);
	endtask
	// Check both flags, then clear them for the next command
	task flags(input logic [1:0] e);
		acc(1'b0, `REG_FLAGS, 32'h0, 32'h3, {30'h0, e});
		acc(1'b1, `REG_FLAGS, 32'h3, 32'h0, 32'h0);
	endtask
	task setup(input logic [7:0] n, input logic [23:0] a);
		issue(`OP_MBX_SETUP);
		put(n);
		put(a[23:16]);
		put(a[15:8]);
		put(a[7:0]);
		settle;
	endtask
	task stopTest;
		$display("Compared %0d mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Read results checked against the oldest note
	always @(posedge clk)
		if (wb_ack_o && wb_cyc_i && !wb_we_i && expQ.size() > 0)
		begin
			chk("readback", wb_dat_o & expQ[0][63:32], expQ[0][31:0]);
			void'(expQ.pop_front());
		end
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			stopTest;
		end
	end
	initial
	begin
		seed = 90;
		{nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, en} = 0;
		wb_sel_i = 4'hF;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		chk("initreq", initRequired_r, 1);
		acc(1'b0, `REG_STATUS, 32'h0, 32'h0000_003C, (32'h0000_0001 << `ST_INIT_REQ) | (32'h0000_0001 << `ST_IDLE));
		put(`OP_START_SCAN);
		settle;
		flags(2'h3);
		setup(8'h00, 24'h12_3456);
		flags(2'h3);
		chk("initreq", initRequired_r, 1);
		mbxN = 8'($random(seed)) | 8'h01;
		mbxA = 24'($random(seed));
		setup(mbxN, mbxA);
		flags(2'h1);
		chk("base", mbxBase_r, mbxA);
		chk("count", mbxCount_r, mbxN);
		chk("inbase", mbxInBase_r, 24'(mbxA + 4 * mbxN));
		chk("area", mbxAreaBytes_r, 11'(mbxN) * 8);
		chk("initreq", initRequired_r, 0);
		acc(1'b0, `REG_STATUS, 32'h0, 32'h0000_003C, 32'h0000_0001 << `ST_IDLE);
		put(`OP_START_SCAN);
		settle;
		chk("scan", scanActive_r, 1);
		flags(2'h0);
		repeat (60) @(posedge clk);
		chk("scan", scanActive_r, 0);
		issue(`OP_INQUIRY);
		for (i = 0; i < 4; i++)
		begin
			do acc(1'b0, `REG_STATUS, 32'h0, 32'h0, 32'h0); while (!rd[`ST_DATA_IN_FULL]);
			chk("complete", commandComplete_r, 0);
			acc(1'b0, `REG_DATA_IN, 32'h0, 32'hFF, {24'h0, idb[i]});
		end
		settle;
		flags(2'h1);
		// enable, bad byte, then disable again
		for (i = 0; i < 3; i++)
		begin
			v = 8'((i + 1) % 3);
			en = v < 2 ? v[0] : en;
			issue(`OP_OUT_INT);
			put(v);
			settle;
			chk("inten", outIntEnable_r, en);
			flags(v < 2 ? 2'h0 : 2'h3);
		end
		issue(`OP_FW_BOOT);
		settle;
		flags(2'h3);
		// No-op completes; undefined opcodes are refused
		issue(`OP_NOP);
		settle;
		flags(2'h1);
		v = 8'($random(seed)) | 8'h08;
		issue(v);
		settle;
		flags(2'h3);
		stopTest;
	end
endmodule // tb_top
`default_nettype wire
